// ===== logic/dc_ctrl_pkg.sv
package dc_ctrl_pkg;
  // timing base
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned MS_CNT_W = 15;
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
  // durations in milliseconds, then setting and counter widths in bits
  localparam int unsigned OPER_PULSE_MS = 150;
  localparam int unsigned MIN_PULSE_MS = 1000;
  localparam int unsigned PULSE_MS_MIN = 100;
  localparam int unsigned INTER_MS_MIN = 20;
  localparam int unsigned SET_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam logic [SET_W-1:0] OPER_PULSE_TICKS = SET_W'(OPER_PULSE_MS);
  localparam logic [SET_W-1:0] MIN_PULSE_TICKS = SET_W'(MIN_PULSE_MS);
  // position state codes
  typedef enum logic [1:0] {
    POS_INTER = 2'h0,
    POS_OFF = 2'h1,
    POS_ON = 2'h2,
    POS_BAD = 2'h3
  } pos_t;
  // command channel values
  localparam logic CMD_VAL_OFF = 1'b0;
  localparam logic CMD_VAL_ON = 1'b1;
endpackage

// ===== logic/disconnector_control_outputs.sv
`timescale 1ns/1ns
module disconnector_control_outputs #(
  parameter int unsigned TICK_CYCLES = dc_ctrl_pkg::MS_CYCLES // clock cycles per millisecond tick
) (
  input wire logic clk, // 25 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic openPositionInput, // open feedback pin
  input wire logic closedPositionInput, // closed feedback pin
  input wire logic localEnable, // local control allowed
  input wire logic remoteEnable, // remote control allowed
  input wire logic openPermit, // interlock open enable
  input wire logic closePermit, // interlock close enable
  input wire logic operationBlock, // blocks all commands
  input wire logic localCmdValid, // local panel command strobe
  input wire logic localCmdValue, // 0 off, 1 on
  input wire logic operateCommandValid, // remote channel strobe
  input wire logic operateCommandValue, // 0 off, 1 on
  input wire logic counterReset, // clear operation counter
  input wire logic [15:0] pulseDurationMs, // command pulse setting
  input wire logic [15:0] maxIntermediateMs, // intermediate filter setting
  output logic offCommandPulse, // open coil command
  output logic onCommandPulse, // close coil command
  output logic operationPulse, // 150 ms operation pulse
  output logic closedInd, // filtered closed
  output logic openedInd, // filtered opened
  output logic [1:0] positionStateCode, // filtered state code
  output logic statusEvent, // one cycle on code change
  output logic [15:0] operationCount // operation counter
);
  typedef struct packed {
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [14:0] msDiv;
    logic offCmd;
    logic onCmd;
    logic [15:0] cmdMs;
    logic [15:0] cmdLen;
    logic oper;
    logic [15:0] operMs;
    logic [15:0] interMs;
    logic [1:0] code;
    logic evt;
    logic [15:0] count;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic tick;
  logic [1:0] rawCode;
  logic cmdReq;
  logic cmdVal;
  logic cmdPerm;
  logic [15:0] pulseSet;
  logic [15:0] interSet;

  // raw position code from synchronised pins
  assign rawCode = {s_reg.syncB[1], s_reg.syncB[0]};
  // tick length is a parameter so short runs can scale time down
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
  assign tick = (s_reg.msDiv == TICK_LAST);
  // remote channel wins when both strobe in one cycle
  assign cmdReq = (localCmdValid & localEnable) | (operateCommandValid & remoteEnable);
  assign cmdVal = (operateCommandValid & remoteEnable) ? operateCommandValue : localCmdValue;
  // settings clamped to documented minimum, keeps counters sane
  assign pulseSet = (pulseDurationMs < 16'(dc_ctrl_pkg::PULSE_MS_MIN)) ?
                    16'(dc_ctrl_pkg::PULSE_MS_MIN) : pulseDurationMs;
  assign interSet = (maxIntermediateMs < 16'(dc_ctrl_pkg::INTER_MS_MIN)) ?
                    16'(dc_ctrl_pkg::INTER_MS_MIN) : maxIntermediateMs;

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.evt = 1'b0;
    cmdPerm = (cmdVal == dc_ctrl_pkg::CMD_VAL_OFF) ? openPermit : closePermit;
    // pins: bit0 open, bit1 closed, two-stage sync
    s_next.syncA = {closedPositionInput, openPositionInput};
    s_next.syncB = s_reg.syncA;
    s_next.msDiv = tick ? '0 : s_reg.msDiv + 15'h0001;
    // command pulse timing
    if (s_reg.offCmd || s_reg.onCmd) begin
      if (tick) begin
        s_next.cmdMs = s_reg.cmdMs + 16'h0001;
      end
      if ((s_reg.cmdMs >= dc_ctrl_pkg::MIN_PULSE_TICKS) &&
          ((s_reg.offCmd && s_reg.code == dc_ctrl_pkg::POS_OFF) ||
           (s_reg.onCmd && s_reg.code == dc_ctrl_pkg::POS_ON))) begin
        s_next.offCmd = 1'b0;
        s_next.onCmd = 1'b0;
      end
      if (s_reg.cmdMs >= s_reg.cmdLen) begin
        s_next.offCmd = 1'b0;
        s_next.onCmd = 1'b0;
      end
    end else begin
      if (cmdReq && cmdPerm && !operationBlock) begin
        s_next.offCmd = (cmdVal == dc_ctrl_pkg::CMD_VAL_OFF);
        s_next.onCmd = (cmdVal == dc_ctrl_pkg::CMD_VAL_ON);
        s_next.cmdMs = '0;
        s_next.cmdLen = pulseSet;
      end
    end
    // intermediate filter; other codes pass at once
    if (rawCode != dc_ctrl_pkg::POS_INTER) begin
      s_next.interMs = '0;
      s_next.code = rawCode;
    end else if (s_reg.code != dc_ctrl_pkg::POS_INTER) begin
      if (tick) begin
        s_next.interMs = s_reg.interMs + 16'h0001;
      end
      if (s_reg.interMs >= interSet) begin
        s_next.code = dc_ctrl_pkg::POS_INTER;
        s_next.interMs = '0;
      end
    end
    if (s_next.code != s_reg.code) begin
      s_next.evt = 1'b1;
    end
    // operation pulse on reaching a new end position
    if (s_next.code != s_reg.code &&
        (s_next.code == dc_ctrl_pkg::POS_OFF || s_next.code == dc_ctrl_pkg::POS_ON)) begin
      s_next.oper = 1'b1;
      s_next.operMs = '0;
    end else if (s_reg.oper) begin
      if (tick) begin
        s_next.operMs = s_reg.operMs + 16'h0001;
      end
      if (s_reg.operMs >= dc_ctrl_pkg::OPER_PULSE_TICKS) begin
        s_next.oper = 1'b0;
      end
    end
    // count rising edge; reset clears, a same-cycle edge then counts from zero to 1
    if (counterReset) begin
      s_next.count = '0;
    end
    if (s_next.oper && !s_reg.oper) begin
      s_next.count = (counterReset ? 16'h0000 : s_reg.count) + 16'h0001;
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign offCommandPulse = s_reg.offCmd;
  assign onCommandPulse = s_reg.onCmd;
  assign operationPulse = s_reg.oper;
  assign positionStateCode = s_reg.code;
  // filtered outputs derive from the code only
  assign openedInd = (s_reg.code == dc_ctrl_pkg::POS_OFF);
  assign closedInd = (s_reg.code == dc_ctrl_pkg::POS_ON);
  assign statusEvent = s_reg.evt;
  assign operationCount = s_reg.count;

  // assertions
  // pulses never overlap
  a_cmd_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(offCommandPulse && onCommandPulse)) else $error("both command pulses active");
  a_block_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(offCommandPulse | onCommandPulse) |-> !$past(operationBlock)) else $error("command while blocked");
  a_open_permit: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(offCommandPulse) |-> $past(openPermit)) else $error("open without permit");
  a_close_permit: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(onCommandPulse) |-> $past(closePermit)) else $error("close without permit");
  a_min_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(offCommandPulse | onCommandPulse) |-> $past(s_reg.cmdMs) >= dc_ctrl_pkg::MIN_PULSE_TICKS ||
    $past(s_reg.cmdMs) >= $past(s_reg.cmdLen)) else $error("pulse too short");
  a_opened_code: assert property (@(posedge clk) disable iff (!rst_n)
    openedInd |-> positionStateCode == 2'h1 && !closedInd) else $error("opened mismatch");
  a_event_change: assert property (@(posedge clk) disable iff (!rst_n)
    (positionStateCode != $past(positionStateCode)) |-> statusEvent) else $error("missed event");
  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(operationPulse) |-> operationCount == $past(operationCount) + 16'h0001 ||
    operationCount == 16'h0001) else $error("count not stepped");
  a_count_clear: assert property (@(posedge clk) disable iff (!rst_n)
    counterReset && !s_next.oper |=> operationCount == 16'h0000) else $error("count not cleared");
  a_code_map: assert property (@(posedge clk) disable iff (!rst_n)
    rawCode != 2'h0 |=> positionStateCode == $past(rawCode)) else $error("code mismatch");

  a_cmd_latch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(offCommandPulse | onCommandPulse) |-> s_reg.cmdLen == $past(pulseSet))
    else $error("pulse length not latched");
  a_off_max: assert property (@(posedge clk) disable iff (!rst_n)
    offCommandPulse |-> s_reg.cmdMs <= s_reg.cmdLen)
    else $error("open pulse overran");
  a_on_max: assert property (@(posedge clk) disable iff (!rst_n)
    onCommandPulse |-> s_reg.cmdMs <= s_reg.cmdLen)
    else $error("close pulse overran");
  a_off_hold: assert property (@(posedge clk) disable iff (!rst_n)
    offCommandPulse && s_reg.cmdMs < s_reg.cmdLen && positionStateCode != dc_ctrl_pkg::POS_OFF |=> offCommandPulse)
    else $error("open pulse ended early");
  a_on_hold: assert property (@(posedge clk) disable iff (!rst_n)
    onCommandPulse && s_reg.cmdMs < s_reg.cmdLen && positionStateCode != dc_ctrl_pkg::POS_ON |=> onCommandPulse)
    else $error("close pulse ended early");
  a_off_dir: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(offCommandPulse) |-> $past(cmdVal) == dc_ctrl_pkg::CMD_VAL_OFF)
    else $error("open pulse for on value");
  a_on_dir: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(onCommandPulse) |-> $past(cmdVal) == dc_ctrl_pkg::CMD_VAL_ON)
    else $error("close pulse for off value");
  a_enable_req: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(offCommandPulse | onCommandPulse) |-> $past(cmdReq))
    else $error("command without enabled request");
  a_block_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    operationBlock && !offCommandPulse && !onCommandPulse |=> !offCommandPulse && !onCommandPulse)
    else $error("pulse started while blocked");
  a_early_end: assert property (@(posedge clk) disable iff (!rst_n)
    offCommandPulse && s_reg.cmdMs >= dc_ctrl_pkg::MIN_PULSE_TICKS &&
    positionStateCode == dc_ctrl_pkg::POS_OFF |=> !offCommandPulse) else $error("open pulse not withdrawn");
  a_oper_entry: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(operationPulse) |-> statusEvent && (openedInd || closedInd))
    else $error("operation pulse without new position");
  a_oper_len: assert property (@(posedge clk) disable iff (!rst_n)
    operationPulse |-> s_reg.operMs <= dc_ctrl_pkg::OPER_PULSE_TICKS)
    else $error("operation pulse overran");
  a_oper_stay: assert property (@(posedge clk) disable iff (!rst_n)
    operationPulse && s_reg.operMs < dc_ctrl_pkg::OPER_PULSE_TICKS |=> operationPulse)
    else $error("operation pulse too short");
  a_closed_code: assert property (@(posedge clk) disable iff (!rst_n)
    closedInd |-> positionStateCode == dc_ctrl_pkg::POS_ON && !openedInd)
    else $error("closed mismatch");
  a_close_settle: assert property (@(posedge clk) disable iff (!rst_n)
    rawCode == dc_ctrl_pkg::POS_ON |=> closedInd)
    else $error("closed not shown");
  a_open_settle: assert property (@(posedge clk) disable iff (!rst_n)
    rawCode == dc_ctrl_pkg::POS_OFF |=> openedInd)
    else $error("opened not shown");
  a_bad_code: assert property (@(posedge clk) disable iff (!rst_n)
    rawCode == dc_ctrl_pkg::POS_BAD |=> positionStateCode == dc_ctrl_pkg::POS_BAD)
    else $error("bad state not shown");
  a_inter_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    positionStateCode == dc_ctrl_pkg::POS_INTER || positionStateCode == dc_ctrl_pkg::POS_BAD |->
    !openedInd && !closedInd) else $error("indication in intermediate or bad");
  a_inter_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(positionStateCode) && positionStateCode == dc_ctrl_pkg::POS_INTER |->
    $past(s_reg.interMs) >= $past(interSet)) else $error("intermediate reported early");
  a_event_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    statusEvent |-> $changed(positionStateCode))
    else $error("event without change");
  a_tick_range: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.msDiv <= TICK_LAST)
    else $error("tick divider out of range");
  a_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !$rose(operationPulse) && !$past(counterReset) |-> operationCount == $past(operationCount))
    else $error("count moved without operation");

  // main scenarios reached
  c_open_cmd: cover property (@(posedge clk) disable iff (!rst_n) $rose(offCommandPulse));
  c_close_cmd: cover property (@(posedge clk) disable iff (!rst_n) $rose(onCommandPulse));
  c_oper: cover property (@(posedge clk) disable iff (!rst_n) $fell(operationPulse));
  c_bad: cover property (@(posedge clk) disable iff (!rst_n) positionStateCode == 2'h3);
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) counterReset && operationCount != 16'h0000);
endmodule // disconnector_control_outputs

// ===== verification/switchgear_model.sv
`timescale 1ns/1ns
module switchgear_model (
  input wire logic clk, // bench clock
  input wire logic offCmd, // open coil drive
  input wire logic onCmd, // close coil drive
  input wire logic jam, // both contacts stuck made
  output logic openContact, // open feedback contact
  output logic closedContact // closed feedback contact
);
  int travel = 0;
  logic target = 1'b0;
  initial begin
    openContact = 1'b0;
    closedContact = 1'b0;
  end
  // both contacts drop first, the far one makes after the travel time
  always @(posedge clk) begin
    if (jam) begin
      openContact <= 1'b1;
      closedContact <= 1'b1;
    end else if (travel > 1) begin
      travel <= travel - 1;
    end else if (travel == 1) begin
      travel <= 0;
      openContact <= !target;
      closedContact <= target;
    end else if ((offCmd && !openContact) || (onCmd && !closedContact)) begin
      travel <= 200;
      target <= onCmd;
      openContact <= 1'b0;
      closedContact <= 1'b0;
    end
  end
endmodule // switchgear_model

// ===== verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int MS = 25; // scaled tick keeps the run short
  logic clk = 1'b0, rst_n = 1'b0, locEn = 1'b1, remEn = 1'b1, opPer = 1'b1, clPer = 1'b1, blk = 1'b0;
  logic lv = 1'b0, lval = 1'b0, rv = 1'b0, rval = 1'b0, clr = 1'b0, jam = 1'b0, opC, clC;
  logic [15:0] dur = 16'h0064, inter = 16'h0014;
  logic offP, onP, opP, cInd, oInd, ev;
  logic [1:0] code;
  logic [15:0] cnt;
  int n_mismatch = 0, compares = 0, nEv = 0, opRun = 0, opLen = 0, n = 0;
  always #20 clk = ~clk;
  disconnector_control_outputs #(.TICK_CYCLES(MS)) dut (.clk(clk), .rst_n(rst_n), .openPositionInput(opC),
    .closedPositionInput(clC),
    .localEnable(locEn), .remoteEnable(remEn), .openPermit(opPer), .closePermit(clPer), .operationBlock(blk),
    .localCmdValid(lv), .localCmdValue(lval), .operateCommandValid(rv), .operateCommandValue(rval),
    .counterReset(clr), .pulseDurationMs(dur), .maxIntermediateMs(inter), .offCommandPulse(offP),
    .onCommandPulse(onP), .operationPulse(opP), .closedInd(cInd), .openedInd(oInd), .positionStateCode(code),
    .statusEvent(ev), .operationCount(cnt));
  switchgear_model sw (.clk(clk), .offCmd(offP), .onCmd(onP), .jam(jam), .openContact(opC), .closedContact(clC));
  // event and operation width monitors
  always @(posedge clk) begin
    if (ev === 1'b1) nEv++;
    if (opP === 1'b1) opRun++;
    else if (opRun != 0) begin opLen = opRun; opRun = 0; end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin n_mismatch++; $display("[ERR] %s expected %h seen %h", what, exp, seen); end
  endtask
  // expected code from the contacts, indications decoded from it
  task automatic pos(input int c);
    check("code", 16'(code), 16'(c));
    check("opened", 16'(oInd), 16'(c == 1));
    check("closed", 16'(cInd), 16'(c == 2));
  endtask
  task automatic cmd(input logic remote, input logic v);
    @(negedge clk); if (remote) begin rv = 1'b1; rval = v; end else begin lv = 1'b1; lval = v; end
    @(negedge clk); rv = 1'b0; lv = 1'b0;
  endtask
  // pulse width in cycles; 15 ms tolerance exceeds 5 percent here
  task automatic width(input logic on, input string what);
    n = 0;
    for (int i = 0; i < 100 && (on ? onP : offP) !== 1'b1; i++) @(negedge clk);
    while ((on ? onP : offP) === 1'b1 && n < 20000) begin @(negedge clk); n++; end
    check(what, 16'(n > (dur - 15) * MS && n < (dur + 15) * MS), 16'h0001);
  endtask
  task automatic opDone();
    for (int i = 0; i < 20000 && opP !== 1'b0; i++) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    void'($urandom(73040));
    dur = 16'h0064 + 16'($urandom % 8);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    pos(0);
    check("count", cnt, 16'h0000);
    $display("reset test done");
    blk = 1'b1;
    cmd(1'b0, 1'b0);
    repeat (20) @(negedge clk);
    check("blocked", 16'(offP), 16'h0000);
    blk = 1'b0;
    clPer = 1'b0;
    cmd(1'b1, 1'b1);
    repeat (20) @(negedge clk);
    check("no permit", 16'(onP), 16'h0000);
    clPer = 1'b1;
    $display("refusal test done");
    cmd(1'b0, 1'b0);
    width(1'b0, "off width");
    pos(1);
    check("count", cnt, 16'h0001);
    opDone();
    check("op width", 16'(opLen > 135 * MS && opLen < 165 * MS), 16'h0001);
    $display("open test done");
    cmd(1'b1, 1'b1);
    width(1'b1, "on width");
    pos(2);
    check("count", cnt, 16'h0002);
    opDone();
    $display("close test done");
    jam = 1'b1;
    repeat (10) @(negedge clk);
    pos(3);
    check("events", 16'(nEv), 16'h0003);
    clr = 1'b1;
    repeat (2) @(negedge clk);
    clr = 1'b0;
    check("cleared", cnt, 16'h0000);
    $display("state and clear test done");
    stop_test();
  end
endmodule // testbench
